// File: rtl/ssl_segment_select.sv
`timescale 1ns/10ps
module ssl_segment_select (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Memory reference request
   input  wire logic              ref_valid,
   input  wire ssl_pkg::ssl_ref_e ref_type,
   input  wire logic              ref_frame_base,
   input  wire logic              ref_override_valid,
   input  wire ssl_pkg::ssl_seg_e ref_override_seg,
   input  wire logic [15:0]       ref_disp,
   input  wire logic              ref_disp_is8,
   input  wire logic              ref_base_en,
   input  wire logic [15:0]       ref_base_val,
   input  wire logic              ref_index_en,
   input  wire logic [15:0]       ref_index_val,
   // Direct segment register write
   input  wire logic              seg_wr_en,
   input  wire ssl_pkg::ssl_seg_e seg_wr_sel,
   input  wire logic [15:0]       seg_wr_data,
   // Pointer load from memory
   input  wire logic              ptr_load_valid,
   input  wire ssl_pkg::ssl_ptr_e ptr_load_kind,
   input  wire logic [31:0]       ptr_load_data,
   // Address answer
   output logic                   addr_valid_ff,
   output logic [19:0]            phys_addr_ff,
   output logic [15:0]            eff_offset_ff,
   output logic [15:0]            seg_base_used_ff,
   output ssl_pkg::ssl_seg_e      seg_used_ff,
   // Offset half to destination general register
   output logic                   gpr_wr_valid_ff,
   output logic [15:0]            gpr_wr_data_ff,
   // Segment register contents
   output logic [15:0]            code_segment_base_ff,
   output logic [15:0]            stack_segment_base_ff,
   output logic [15:0]            data_segment_base_ff,
   output logic [15:0]            extra_segment_base_ff
);
   import ssl_pkg::*;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   ssl_seg_e    sel_seg;
   logic [15:0] sel_base;
   logic [15:0] calc_offset;
   logic [19:0] calc_phys;

   logic              nxt_addr_valid;
   logic [19:0]       nxt_phys_addr;
   logic [15:0]       nxt_eff_offset;
   logic [15:0]       nxt_seg_base_used;
   ssl_seg_e          nxt_seg_used;
   logic              nxt_gpr_wr_valid;
   logic [15:0]       nxt_gpr_wr_data;
   logic [15:0]       nxt_code_seg;
   logic [15:0]       nxt_stack_seg;
   logic [15:0]       nxt_data_seg;
   logic [15:0]       nxt_extra_seg;

   // Segment choice
   always_comb begin
      unique case (ref_type)
         SSL_REF_FETCH:    sel_seg = SSL_SEG_CODE;
         SSL_REF_STACK:    sel_seg = SSL_SEG_STACK;
         SSL_REF_STR_DEST: sel_seg = SSL_SEG_EXTRA;
         SSL_REF_DATA: begin
            if (ref_override_valid) begin
               sel_seg = ref_override_seg;
            end else if (ref_frame_base) begin
               sel_seg = SSL_SEG_STACK;
            end else begin
               sel_seg = SSL_SEG_DATA;
            end
         end
      endcase
      unique case (sel_seg)
         SSL_SEG_EXTRA: sel_base = extra_segment_base_ff;
         SSL_SEG_CODE:  sel_base = code_segment_base_ff;
         SSL_SEG_STACK: sel_base = stack_segment_base_ff;
         SSL_SEG_DATA:  sel_base = data_segment_base_ff;
      endcase
   end

   ssl_addr_calc u_calc (
      .disp       (ref_disp),
      .disp_is8   (ref_disp_is8),
      .base_en    (ref_base_en),
      .base_val   (ref_base_val),
      .index_en   (ref_index_en),
      .index_val  (ref_index_val),
      .seg_base   (sel_base),
      .eff_offset (calc_offset),
      .phys_addr  (calc_phys)
   );

   // Address answer; held between requests so the bus unit can reuse it
   always_comb begin
      nxt_addr_valid    = ref_valid;
      nxt_phys_addr     = phys_addr_ff;
      nxt_eff_offset    = eff_offset_ff;
      nxt_seg_base_used = seg_base_used_ff;
      nxt_seg_used      = seg_used_ff;
      if (ref_valid) begin
         nxt_phys_addr     = calc_phys;
         nxt_eff_offset    = calc_offset;
         nxt_seg_base_used = sel_base;
         nxt_seg_used      = sel_seg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         addr_valid_ff    <= 1'b0;
         phys_addr_ff     <= 20'h00000;
         eff_offset_ff    <= 16'h0000;
         seg_base_used_ff <= 16'h0000;
         seg_used_ff      <= SSL_SEG_CODE;
      end else begin
         addr_valid_ff    <= nxt_addr_valid;
         phys_addr_ff     <= nxt_phys_addr;
         eff_offset_ff    <= nxt_eff_offset;
         seg_base_used_ff <= nxt_seg_base_used;
         seg_used_ff      <= nxt_seg_used;
      end
   end

   // Segment registers; a pointer load wins over a direct write to the same register
   always_comb begin
      nxt_code_seg     = code_segment_base_ff;
      nxt_stack_seg    = stack_segment_base_ff;
      nxt_data_seg     = data_segment_base_ff;
      nxt_extra_seg    = extra_segment_base_ff;
      nxt_gpr_wr_valid = ptr_load_valid;
      nxt_gpr_wr_data  = gpr_wr_data_ff;
      if (seg_wr_en) begin
         unique case (seg_wr_sel)
            SSL_SEG_EXTRA: nxt_extra_seg = seg_wr_data;
            SSL_SEG_CODE:  nxt_code_seg  = seg_wr_data;
            SSL_SEG_STACK: nxt_stack_seg = seg_wr_data;
            SSL_SEG_DATA:  nxt_data_seg  = seg_wr_data;
         endcase
      end
      if (ptr_load_valid) begin
         nxt_gpr_wr_data = ptr_load_data[SSL_PTR_OFS_LO +: SSL_WORD_W];
         if (ptr_load_kind == SSL_PTR_DATA_SEG) begin
            nxt_data_seg = ptr_load_data[SSL_PTR_SEG_LO +: SSL_WORD_W];
         end else begin
            nxt_extra_seg = ptr_load_data[SSL_PTR_SEG_LO +: SSL_WORD_W];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         code_segment_base_ff  <= SSL_CODE_RST;
         stack_segment_base_ff <= SSL_DATA_RST;
         data_segment_base_ff  <= SSL_DATA_RST;
         extra_segment_base_ff <= SSL_DATA_RST;
         gpr_wr_valid_ff       <= 1'b0;
         gpr_wr_data_ff        <= 16'h0000;
      end else begin
         code_segment_base_ff  <= nxt_code_seg;
         stack_segment_base_ff <= nxt_stack_seg;
         data_segment_base_ff  <= nxt_data_seg;
         extra_segment_base_ff <= nxt_extra_seg;
         gpr_wr_valid_ff       <= nxt_gpr_wr_valid;
         gpr_wr_data_ff        <= nxt_gpr_wr_data;
      end
   end

   sequence fetch_req_s;
      ref_valid && ref_type == SSL_REF_FETCH;
   endsequence
   sequence data_ptr_s;
      ptr_load_valid && ptr_load_kind == SSL_PTR_DATA_SEG;
   endsequence
   sequence extra_ptr_s;
      ptr_load_valid && ptr_load_kind == SSL_PTR_EXTRA_SEG;
   endsequence

   code_fetch_a: assert property (fetch_req_s |=> addr_valid_ff && seg_used_ff == SSL_SEG_CODE
      && seg_base_used_ff == $past(code_segment_base_ff))
      else $error("fetch not addressed through code segment");

   stack_ref_a: assert property (ref_valid && ref_type == SSL_REF_STACK
      |=> seg_used_ff == SSL_SEG_STACK && seg_base_used_ff == $past(stack_segment_base_ff))
      else $error("stack access not through stack segment");

   frame_base_a: assert property (ref_valid && ref_type == SSL_REF_DATA && ref_frame_base
      && !ref_override_valid |=> seg_used_ff == SSL_SEG_STACK)
      else $error("frame based operand not on stack segment");

   dest_string_a: assert property (ref_valid && ref_type == SSL_REF_STR_DEST
      |=> seg_used_ff == SSL_SEG_EXTRA && seg_base_used_ff == $past(extra_segment_base_ff))
      else $error("destination string not on extra segment");

   data_default_a: assert property (ref_valid && ref_type == SSL_REF_DATA && !ref_frame_base
      && !ref_override_valid |=> seg_used_ff == SSL_SEG_DATA)
      else $error("plain data reference not on data segment");

   override_use_a: assert property (ref_valid && ref_type == SSL_REF_DATA && ref_override_valid
      |=> seg_used_ff == $past(ref_override_seg))
      else $error("override prefix ignored");

   override_dest_a: assert property (ref_valid && ref_type == SSL_REF_STR_DEST
      && ref_override_valid && ref_override_seg != SSL_SEG_EXTRA |=> seg_used_ff == SSL_SEG_EXTRA)
      else $error("override redirected destination string");

   ptr_pair_a: assert property (ptr_load_valid |=> gpr_wr_valid_ff
      && gpr_wr_data_ff == $past(ptr_load_data[15:0]))
      else $error("pointer offset half not delivered");

   ptr_data_seg_a: assert property (data_ptr_s |=> data_segment_base_ff
      == $past(ptr_load_data[31:16]))
      else $error("data segment pointer load wrong");

   ptr_extra_seg_a: assert property (extra_ptr_s |=> extra_segment_base_ff
      == $past(ptr_load_data[31:16]))
      else $error("extra segment pointer load wrong");

   phys_form_a: assert property (addr_valid_ff |-> phys_addr_ff
      == 20'({seg_base_used_ff, 4'h0} + {4'h0, eff_offset_ff}))
      else $error("physical address not segment shifted plus offset");

   offset_wrap_a: assert property (ref_valid |=> eff_offset_ff == 16'(
      $past(ref_disp_is8 ? {{8{ref_disp[7]}}, ref_disp[7:0]} : ref_disp)
      + $past(ref_base_en ? ref_base_val : 16'h0000) + $past(ref_index_en ? ref_index_val : 16'h0000)))
      else $error("offset sum wrong");

endmodule

// File: rtl/ssl_pkg.sv
package ssl_pkg;

   // Segment selector codes, shared by override prefix and status output
   typedef enum logic [1:0] {
      SSL_SEG_EXTRA = 2'b00,
      SSL_SEG_CODE  = 2'b01,
      SSL_SEG_STACK = 2'b10,
      SSL_SEG_DATA  = 2'b11
   } ssl_seg_e;

   // Reference classes given by the instruction sequencer
   typedef enum logic [1:0] {
      SSL_REF_FETCH    = 2'b00,
      SSL_REF_STACK    = 2'b01,
      SSL_REF_STR_DEST = 2'b10,
      SSL_REF_DATA     = 2'b11
   } ssl_ref_e;

   // Pointer-load flavours
   typedef enum logic [0:0] {
      SSL_PTR_DATA_SEG  = 1'b0,
      SSL_PTR_EXTRA_SEG = 1'b1
   } ssl_ptr_e;

   localparam int          SSL_WORD_W     = 16;
   localparam int          SSL_PHYS_W     = 20;
   localparam int          SSL_DISP8_W    = 8;
   localparam int          SSL_SEG_SHIFT  = 4;
   localparam int          SSL_PTR_OFS_LO = 0;
   localparam int          SSL_PTR_SEG_LO = 16;
   localparam logic [15:0] SSL_CODE_RST   = 16'hFFFF;
   localparam logic [15:0] SSL_DATA_RST   = 16'h0000;

   // Offset sum: 8-bit displacement sign-extended, carry beyond 16 bits dropped
   function automatic logic [15:0] ssl_eff_offset(
      input logic [15:0] disp,
      input logic        disp_is8,
      input logic        base_en,
      input logic [15:0] base_val,
      input logic        index_en,
      input logic [15:0] index_val
   );
      logic [15:0] d;
      logic [15:0] b;
      logic [15:0] x;
      d = disp_is8 ? {{8{disp[7]}}, disp[7:0]} : disp;
      b = base_en ? base_val : 16'h0000;
      x = index_en ? index_val : 16'h0000;
      return 16'(d + b + x);
   endfunction

   // Segment base shifted left four, plus offset, 20-bit result
   function automatic logic [19:0] ssl_phys(
      input logic [15:0] seg,
      input logic [15:0] ofs
   );
      return 20'({seg, 4'h0} + {4'h0, ofs});
   endfunction

endpackage

// File: rtl/ssl_addr_calc.sv
`timescale 1ns/10ps
module ssl_addr_calc (
   // Offset terms
   input  wire logic [15:0] disp,
   input  wire logic        disp_is8,
   input  wire logic        base_en,
   input  wire logic [15:0] base_val,
   input  wire logic        index_en,
   input  wire logic [15:0] index_val,
   // Selected segment base
   input  wire logic [15:0] seg_base,
   // Results
   output logic      [15:0] eff_offset,
   output logic      [19:0] phys_addr
);
   import ssl_pkg::*;

   always_comb begin
      eff_offset = ssl_eff_offset(disp, disp_is8, base_en, base_val, index_en, index_val);
      phys_addr  = ssl_phys(seg_base, eff_offset);
   end

endmodule

// File: tb/ssl_ptr_mem.sv
`timescale 1ns/10ps
module ssl_ptr_mem (
   // Pointer fetch from memory
   input  wire logic [19:0] addr,
   output logic      [31:0] data
);
   // Offset in the low half, segment in the high half; both halves vary with the address
   assign data = {addr[19:4] + 16'h0101, addr[15:0] ^ 16'h5A3C};
endmodule

// File: tb/test_segment_select_logic.sv
`timescale 1ns/10ps
module test_segment_select_logic;
   import ssl_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        ref_valid, ref_frame_base, ref_override_valid, ref_disp_is8, ref_base_en, ref_index_en;
   ssl_ref_e    ref_type;
   ssl_seg_e    ref_override_seg, seg_wr_sel, seg_used_ff;
   logic [15:0] ref_disp, ref_base_val, ref_index_val, seg_wr_data;
   logic        seg_wr_en, ptr_load_valid, addr_valid_ff, gpr_wr_valid_ff;
   ssl_ptr_e    ptr_load_kind;
   logic [31:0] ptr_load_data;
   logic [19:0] ptr_addr, phys_addr_ff;
   logic [15:0] eff_offset_ff, seg_base_used_ff, gpr_wr_data_ff;
   logic [15:0] code_segment_base_ff, stack_segment_base_ff, data_segment_base_ff, extra_segment_base_ff;
   logic [15:0] sh [4];
   logic [53:0] exp_q [$];
   logic [15:0] gpr_q [$];
   int          seed, miscompares, checked, cycles;

   always #25 clk_sys = ~clk_sys;

   ssl_segment_select uut (.clk_sys(clk_sys), .rst_n(rst_n), .ref_valid(ref_valid), .ref_type(ref_type),
      .ref_frame_base(ref_frame_base), .ref_override_valid(ref_override_valid),
      .ref_override_seg(ref_override_seg), .ref_disp(ref_disp), .ref_disp_is8(ref_disp_is8),
      .ref_base_en(ref_base_en), .ref_base_val(ref_base_val), .ref_index_en(ref_index_en),
      .ref_index_val(ref_index_val), .seg_wr_en(seg_wr_en), .seg_wr_sel(seg_wr_sel),
      .seg_wr_data(seg_wr_data), .ptr_load_valid(ptr_load_valid), .ptr_load_kind(ptr_load_kind),
      .ptr_load_data(ptr_load_data), .addr_valid_ff(addr_valid_ff), .phys_addr_ff(phys_addr_ff),
      .eff_offset_ff(eff_offset_ff), .seg_base_used_ff(seg_base_used_ff), .seg_used_ff(seg_used_ff),
      .gpr_wr_valid_ff(gpr_wr_valid_ff), .gpr_wr_data_ff(gpr_wr_data_ff),
      .code_segment_base_ff(code_segment_base_ff), .stack_segment_base_ff(stack_segment_base_ff),
      .data_segment_base_ff(data_segment_base_ff), .extra_segment_base_ff(extra_segment_base_ff));

   ssl_ptr_mem ptr_mem (.addr(ptr_addr), .data(ptr_load_data));

   task automatic cmp(input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (e !== g) begin
         miscompares++;
         $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic give_verdict();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic quiet();
      {ref_valid, ref_frame_base, ref_override_valid, ref_disp_is8, ref_base_en, ref_index_en} = '0;
      {ref_disp, ref_base_val, ref_index_val, seg_wr_data, ptr_addr} = '0;
      {seg_wr_en, ptr_load_valid} = '0;
      ref_type = SSL_REF_FETCH;
      ref_override_seg = SSL_SEG_EXTRA;
      seg_wr_sel = SSL_SEG_EXTRA;
      ptr_load_kind = SSL_PTR_DATA_SEG;
   endtask

   // Expectation uses segment values before any same-edge write
   task automatic drive_cycle();
      ssl_seg_e    s;
      logic [15:0] d, ofs;
      @(negedge clk_sys);
      {ref_frame_base, ref_override_valid, ref_disp_is8, ref_base_en, ref_index_en} = 5'($random(seed));
      ref_valid = ($random(seed) & 3) != 0;
      ref_type = ssl_ref_e'(2'($random(seed)));
      ref_override_seg = ssl_seg_e'(2'($random(seed)));
      {ref_disp, ref_base_val} = $random(seed);
      ref_index_val = 16'($random(seed));
      seg_wr_en = ($random(seed) & 3) == 0;
      seg_wr_sel = ssl_seg_e'(2'($random(seed)));
      seg_wr_data = 16'($random(seed));
      ptr_load_valid = ($random(seed) & 3) == 0;
      ptr_load_kind = ssl_ptr_e'(1'($random(seed)));
      ptr_addr = 20'($random(seed));
      #1;
      if (ref_valid) begin
         d = ref_disp_is8 ? {{8{ref_disp[7]}}, ref_disp[7:0]} : ref_disp;
         ofs = d + (ref_base_en ? ref_base_val : 16'h0000) + (ref_index_en ? ref_index_val : 16'h0000);
         case (ref_type)
            SSL_REF_FETCH: s = SSL_SEG_CODE;
            SSL_REF_STACK: s = SSL_SEG_STACK;
            SSL_REF_STR_DEST: s = SSL_SEG_EXTRA;
            default: s = ref_override_valid ? ref_override_seg : (ref_frame_base ? SSL_SEG_STACK : SSL_SEG_DATA);
         endcase
         exp_q.push_back({s, sh[s], ofs, 20'({sh[s], 4'h0} + {4'h0, ofs})});
      end
      if (seg_wr_en) begin
         sh[seg_wr_sel] = seg_wr_data;
      end
      if (ptr_load_valid) begin
         sh[ptr_load_kind ? 0 : 3] = ptr_load_data[31:16];
         gpr_q.push_back(ptr_load_data[15:0]);
      end
   endtask

   always @(posedge clk_sys) begin
      #1;
      cmp(64'({sh[0], sh[1], sh[2], sh[3]}), 64'({extra_segment_base_ff, code_segment_base_ff, stack_segment_base_ff, data_segment_base_ff}));
      cmp(64'({ref_valid & rst_n, ptr_load_valid & rst_n}), 64'({addr_valid_ff, gpr_wr_valid_ff}));
      if (addr_valid_ff === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp(64'h1, 64'h0);
         end else begin
            cmp(64'(exp_q.pop_front()), 64'({seg_used_ff, seg_base_used_ff, eff_offset_ff, phys_addr_ff}));
         end
      end
      if (gpr_wr_valid_ff === 1'b1) begin
         if (gpr_q.size() == 0) begin
            cmp(64'h1, 64'h0);
         end else begin
            cmp(64'(gpr_q.pop_front()), 64'(gpr_wr_data_ff));
         end
      end
   end

   // Ceiling well above the roughly 630 cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         give_verdict();
      end
   end

   initial begin
      seed = 9197;
      quiet();
      sh = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (300) drive_cycle();
      @(negedge clk_sys);
      rst_n = 1'b0;
      quiet();
      sh = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (300) drive_cycle();
      @(negedge clk_sys);
      quiet();
      repeat (3) @(negedge clk_sys);
      cmp(64'h0, 64'(exp_q.size() + gpr_q.size()));
      give_verdict();
   end
endmodule
